// ==== crs_map.svh ====
// Purpose: constants of the cpu core register set
// Assumes: included by crs_core_regs.sv only
// Notes: offsets, field positions, reset values and stack steps
`ifndef CRS_MAP_SVH
`define CRS_MAP_SVH
`define CRS_FLAGS_ADDR 8'hf7
`define CRS_F_GIE 0
`define CRS_F_ZERO 1
`define CRS_F_CARRY 2
`define CRS_F_SUPER 3
`define CRS_F_BANK 4
`define CRS_F_USER_MASK 8'h17
`define CRS_FLAGS_RST 8'h02
`define CRS_REG_RST 8'h00
`define CRS_PC_RST 16'h0000
`define CRS_SP_PUSH 8'h01
`define CRS_SP_CALL 8'h02
`define CRS_SP_RET 8'h02
`define CRS_SP_INT_RET 8'h03
`endif

// ==== crs_pkg.sv ====
// Purpose: types of the cpu core register set
// Assumes: used with crs_map.svh
// Notes: the sequencer hands one retired instruction per request
package crs_pkg;
    typedef enum logic [1:0] {
        CRS_SRC_NONE = 2'b00,
        CRS_SRC_IMM = 2'b01,
        CRS_SRC_DIR = 2'b10,
        CRS_SRC_IDX = 2'b11
    } crs_src_mode_t;
    typedef enum logic [1:0] {
        CRS_DST_A = 2'b00,
        CRS_DST_X = 2'b01,
        CRS_DST_F = 2'b10,
        CRS_DST_SP = 2'b11
    } crs_dst_t;
    typedef enum logic [3:0] {
        CRS_OP_MOV = 4'h0,
        CRS_OP_ADD = 4'h1,
        CRS_OP_ADC = 4'h2,
        CRS_OP_SUB = 4'h3,
        CRS_OP_AND = 4'h4,
        CRS_OP_OR = 4'h5,
        CRS_OP_XOR = 4'h6,
        CRS_OP_SHL = 4'h7,
        CRS_OP_PUSH = 4'h8,
        CRS_OP_POP = 4'h9,
        CRS_OP_CALL = 4'ha,
        CRS_OP_LONG_CALL = 4'hb,
        CRS_OP_RET = 4'hc,
        CRS_OP_INT_RET = 4'hd,
        CRS_OP_SWAP = 4'he,
        CRS_OP_JUMP = 4'hf
    } crs_op_t;
    typedef struct packed {
        crs_op_t op;
        crs_src_mode_t mode;
        crs_dst_t dst;
        logic reg_space;
        logic [7:0] operand;
        logic [1:0] len;
        logic [15:0] target;
    } crs_instr_t;
    typedef enum logic [0:0] {
        CRS_ST_IDLE = 1'b0,
        CRS_ST_WAIT = 1'b1
    } crs_state_t;
endpackage

// ==== crs_core_regs.sv ====
// Purpose: cpu core registers and source operand address forming
// Assumes: sequencer and memories run on core_clk_i
// Notes: memory data is taken in the same cycle that mem_rd_o is high
`timescale 1ns/100ps
`include "crs_map.svh"
module crs_core_regs (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic exec_valid_i,
    input wire crs_pkg::crs_instr_t exec_i,
    input wire logic super_i,
    input wire logic [7:0] mem_rdata_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    output logic busy_o,
    output logic done_o,
    output logic mem_rd_o,
    output logic mem_reg_space_o,
    output logic [7:0] mem_addr_o,
    output logic reg_rvalid_o,
    output logic [7:0] reg_rdata_o,
    output logic [7:0] acc_o,
    output logic [7:0] idx_o,
    output logic [7:0] sp_o,
    output logic [15:0] pc_o,
    output logic [7:0] flags_o,
    output logic gie_o,
    output logic bank_o
);
    crs_pkg::crs_state_t state_q;
    crs_pkg::crs_instr_t instr_q;
    logic [7:0] acc_q;
    logic [7:0] idx_q;
    logic [7:0] sp_q;
    logic [15:0] pc_q;
    logic [7:0] flags_q;
    logic do_exec;
    crs_pkg::crs_instr_t cur;
    logic [7:0] src;
    logic [7:0] lhs;
    logic [8:0] res;
    logic is_alu;
    logic is_logic;

    // an instruction retires now, either immediate or after its memory read
    assign cur = (state_q == crs_pkg::CRS_ST_WAIT) ? instr_q : exec_i;
    assign do_exec = (state_q == crs_pkg::CRS_ST_WAIT) ||
                     (exec_valid_i && exec_i.mode != crs_pkg::CRS_SRC_DIR &&
                      exec_i.mode != crs_pkg::CRS_SRC_IDX);
    assign src = (state_q == crs_pkg::CRS_ST_WAIT) ? mem_rdata_i : exec_i.operand;
    assign lhs = (cur.dst == crs_pkg::CRS_DST_X) ? idx_q :
                 (cur.dst == crs_pkg::CRS_DST_F) ? flags_q :
                 (cur.dst == crs_pkg::CRS_DST_SP) ? sp_q : acc_q;
    assign is_logic = cur.op == crs_pkg::CRS_OP_AND || cur.op == crs_pkg::CRS_OP_OR ||
                      cur.op == crs_pkg::CRS_OP_XOR;
    assign is_alu = is_logic || cur.op == crs_pkg::CRS_OP_ADD || cur.op == crs_pkg::CRS_OP_ADC ||
                    cur.op == crs_pkg::CRS_OP_SUB || cur.op == crs_pkg::CRS_OP_SHL;

    always_comb begin
        unique case (cur.op)
            crs_pkg::CRS_OP_ADD: res = {1'b0, lhs} + {1'b0, src};
            crs_pkg::CRS_OP_ADC: res = {1'b0, lhs} + {1'b0, src} + {8'h00, flags_q[`CRS_F_CARRY]};
            crs_pkg::CRS_OP_SUB: res = {1'b0, lhs} - {1'b0, src};
            crs_pkg::CRS_OP_AND: res = {1'b0, lhs & src};
            crs_pkg::CRS_OP_OR: res = {1'b0, lhs | src};
            crs_pkg::CRS_OP_XOR: res = {1'b0, lhs ^ src};
            crs_pkg::CRS_OP_SHL: res = {src, 1'b0};
            default: res = {1'b0, src};
        endcase
    end

    // sequencer: direct and indexed sources stall one cycle for the read
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= crs_pkg::CRS_ST_IDLE;
            instr_q <= '0;
        end else begin
            unique case (state_q)
                crs_pkg::CRS_ST_IDLE: begin
                    if (exec_valid_i && !do_exec) begin
                        state_q <= crs_pkg::CRS_ST_WAIT;
                        instr_q <= exec_i;
                    end
                end
                crs_pkg::CRS_ST_WAIT: state_q <= crs_pkg::CRS_ST_IDLE;
            endcase
        end
    end

    // source address forming; requests during WAIT are ignored
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mem_rd_o <= 1'b0;
            mem_addr_o <= `CRS_REG_RST;
            mem_reg_space_o <= 1'b0;
        end else begin
            mem_rd_o <= (state_q == crs_pkg::CRS_ST_IDLE) && exec_valid_i && !do_exec;
            if ((state_q == crs_pkg::CRS_ST_IDLE) && exec_valid_i && !do_exec) begin
                mem_reg_space_o <= exec_i.reg_space;
                if (exec_i.mode == crs_pkg::CRS_SRC_IDX) begin
                    mem_addr_o <= exec_i.operand + idx_q;
                end else begin
                    mem_addr_o <= exec_i.operand;
                end
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            busy_o <= (state_q == crs_pkg::CRS_ST_IDLE) && exec_valid_i && !do_exec;
            done_o <= do_exec;
        end
    end

    // accumulator
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_q <= `CRS_REG_RST;
        end else if (do_exec && cur.dst == crs_pkg::CRS_DST_A) begin
            if (is_alu || cur.op == crs_pkg::CRS_OP_MOV || cur.op == crs_pkg::CRS_OP_POP) begin
                acc_q <= res[7:0];
            end
        end else if (do_exec && cur.op == crs_pkg::CRS_OP_SWAP) begin
            acc_q <= lhs;
        end
    end

    // index register
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            idx_q <= `CRS_REG_RST;
        end else if (do_exec && cur.dst == crs_pkg::CRS_DST_X) begin
            if (cur.op == crs_pkg::CRS_OP_SWAP) begin
                idx_q <= acc_q;
            end else if (is_alu || cur.op == crs_pkg::CRS_OP_MOV || cur.op == crs_pkg::CRS_OP_POP) begin
                idx_q <= res[7:0];
            end
        end
    end

    // stack pointer always names the top of the stack
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sp_q <= `CRS_REG_RST;
        end else if (do_exec) begin
            unique case (cur.op)
                crs_pkg::CRS_OP_PUSH: sp_q <= sp_q + `CRS_SP_PUSH;
                crs_pkg::CRS_OP_POP: sp_q <= sp_q - `CRS_SP_PUSH;
                crs_pkg::CRS_OP_CALL,
                crs_pkg::CRS_OP_LONG_CALL: sp_q <= sp_q + `CRS_SP_CALL;
                crs_pkg::CRS_OP_RET: sp_q <= sp_q - `CRS_SP_RET;
                crs_pkg::CRS_OP_INT_RET: sp_q <= sp_q - `CRS_SP_INT_RET;
                crs_pkg::CRS_OP_SWAP: begin
                    if (cur.dst == crs_pkg::CRS_DST_SP) begin
                        sp_q <= acc_q;
                    end
                end
                crs_pkg::CRS_OP_ADD,
                crs_pkg::CRS_OP_MOV: begin
                    if (cur.dst == crs_pkg::CRS_DST_SP) begin
                        sp_q <= res[7:0];
                    end
                end
                default: sp_q <= sp_q;
            endcase
        end
    end

    // program counter, full sixteen bits even though code space is smaller
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pc_q <= `CRS_PC_RST;
        end else if (do_exec) begin
            if (cur.op == crs_pkg::CRS_OP_CALL || cur.op == crs_pkg::CRS_OP_LONG_CALL ||
                cur.op == crs_pkg::CRS_OP_RET || cur.op == crs_pkg::CRS_OP_INT_RET ||
                cur.op == crs_pkg::CRS_OP_JUMP) begin
                pc_q <= cur.target;
            end else begin
                pc_q <= pc_q + {14'h0000, cur.len};
            end
        end
    end

    // flags: supervisory bit always follows hardware, user writes cannot touch it
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flags_q <= `CRS_FLAGS_RST;
        end else begin
            flags_q[`CRS_F_SUPER] <= super_i;
            if (do_exec && cur.dst == crs_pkg::CRS_DST_F) begin
                if (is_logic) begin
                    flags_q[`CRS_F_BANK] <= res[`CRS_F_BANK];
                    flags_q[`CRS_F_CARRY] <= res[`CRS_F_CARRY];
                    flags_q[`CRS_F_ZERO] <= res[`CRS_F_ZERO];
                    flags_q[`CRS_F_GIE] <= res[`CRS_F_GIE];
                end
            end else if (do_exec && is_alu && cur.dst != crs_pkg::CRS_DST_SP) begin
                flags_q[`CRS_F_CARRY] <= res[8];
                flags_q[`CRS_F_ZERO] <= (res[7:0] == 8'h00);
            end
            flags_q[7:5] <= 3'h0;
        end
    end

    // only the flags answer in register space, and only at their one address
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rvalid_o <= 1'b0;
            reg_rdata_o <= `CRS_REG_RST;
        end else begin
            reg_rvalid_o <= reg_rd_i && (reg_addr_i == `CRS_FLAGS_ADDR);
            reg_rdata_o <= (reg_rd_i && reg_addr_i == `CRS_FLAGS_ADDR) ? flags_q : 8'h00;
        end
    end

    assign acc_o = acc_q;
    assign idx_o = idx_q;
    assign sp_o = sp_q;
    assign pc_o = pc_q;
    assign flags_o = flags_q;
    assign gie_o = flags_q[`CRS_F_GIE];
    assign bank_o = flags_q[`CRS_F_BANK];

    default clocking ck @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_issue_direct;
        exec_valid_i && state_q == crs_pkg::CRS_ST_IDLE && exec_i.mode == crs_pkg::CRS_SRC_DIR;
    endsequence
    sequence s_read_then_done;
        mem_rd_o && busy_o ##1 done_o && !busy_o;
    endsequence

    AST_DIRECT_FLOW: assert property (s_issue_direct |=> s_read_then_done)
        else $error("direct source did not read then retire");
    AST_INDEX_ADDR: assert property (exec_valid_i && state_q == crs_pkg::CRS_ST_IDLE &&
        exec_i.mode == crs_pkg::CRS_SRC_IDX |=> mem_addr_o == $past(exec_i.operand) + $past(idx_q))
        else $error("indexed address is not operand plus index");
    AST_IMM_NO_READ: assert property (exec_valid_i && state_q == crs_pkg::CRS_ST_IDLE &&
        exec_i.mode == crs_pkg::CRS_SRC_IMM |=> !mem_rd_o && done_o)
        else $error("immediate source touched memory");
    AST_FLAGS_RESERVED: assert property (flags_o[7:5] == 3'h0)
        else $error("reserved flag bits not zero");
    AST_SUPER_FOLLOWS: assert property (##1 flags_o[`CRS_F_SUPER] == $past(super_i))
        else $error("supervisory bit does not follow hardware");
    AST_PUSH_SP: assert property (do_exec && cur.op == crs_pkg::CRS_OP_PUSH |=> sp_o == $past(sp_q) + 8'h01)
        else $error("push did not grow stack by one");
    AST_PC_STEP: assert property (do_exec && (cur.op == crs_pkg::CRS_OP_MOV || is_alu)
        |=> pc_o == $past(pc_q) + {14'h0000, $past(cur.len)})
        else $error("pc did not advance by length");
    AST_ZERO_FLAG: assert property (do_exec && is_alu && cur.dst == crs_pkg::CRS_DST_A
        |=> flags_o[`CRS_F_ZERO] == (acc_o == 8'h00))
        else $error("zero flag disagrees with accumulator");
    AST_CALL_SP: assert property (do_exec && (cur.op == crs_pkg::CRS_OP_CALL ||
        cur.op == crs_pkg::CRS_OP_LONG_CALL) |=> sp_o == $past(sp_q) + `CRS_SP_CALL)
        else $error("call did not grow stack by two");
    AST_RET_SP: assert property (do_exec && cur.op == crs_pkg::CRS_OP_RET |=>
        sp_o == $past(sp_q) - `CRS_SP_RET)
        else $error("return did not shrink stack by two");
    AST_INT_RET_SP: assert property (do_exec && cur.op == crs_pkg::CRS_OP_INT_RET |=>
        sp_o == $past(sp_q) - `CRS_SP_INT_RET)
        else $error("interrupt return did not shrink stack by three");
    AST_PC_LOAD: assert property (do_exec && cur.op == crs_pkg::CRS_OP_JUMP |=>
        pc_o == $past(cur.target))
        else $error("jump did not load its target");
    AST_FLAG_DATA: assert property (reg_rd_i && reg_addr_i == `CRS_FLAGS_ADDR |=>
        reg_rvalid_o && reg_rdata_o == $past(flags_q))
        else $error("flag read did not return the flags");
    AST_F_ARITH_KEEPS: assert property (do_exec && cur.dst == crs_pkg::CRS_DST_F && !is_logic |=>
        flags_o[`CRS_F_BANK] == $past(flags_q[`CRS_F_BANK]) && flags_o[2:0] == $past(flags_q[2:0]))
        else $error("non-logic op changed the flags");
    AST_FLAG_READ: assert property (reg_rd_i && reg_addr_i != `CRS_FLAGS_ADDR |=> !reg_rvalid_o)
        else $error("core register answered off its address");
endmodule

// ==== crs_core_regs_tb.sv ====
// Purpose: self-checking bench for the cpu core register set
// Assumes: memory data is driven as soon as mem_rd_o shows, held until done_o
// Notes: every request starts one idle edge after the last, so strobes never toggle twice in one step
`timescale 1ns/100ps
module testbench;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic exec_valid_i = 1'b0;
    crs_pkg::crs_instr_t exec_i = '0;
    logic super_i = 1'b0;
    logic [7:0] mem_rdata_i = 8'h00;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic busy_o, done_o, mem_rd_o, mem_reg_space_o, reg_rvalid_o, gie_o, bank_o;
    logic [7:0] mem_addr_o, reg_rdata_o, acc_o, idx_o, sp_o, flags_o;
    logic [15:0] pc_o;
    logic [15:0] exp_pc = 16'h0000;
    int bad_count = 0;
    int check_count = 0;
    int cycles = 0;

    crs_core_regs dut_u (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .exec_valid_i(exec_valid_i),
        .exec_i(exec_i), .super_i(super_i), .mem_rdata_i(mem_rdata_i), .reg_rd_i(reg_rd_i),
        .reg_addr_i(reg_addr_i), .busy_o(busy_o), .done_o(done_o), .mem_rd_o(mem_rd_o),
        .mem_reg_space_o(mem_reg_space_o), .mem_addr_o(mem_addr_o), .reg_rvalid_o(reg_rvalid_o),
        .reg_rdata_o(reg_rdata_o), .acc_o(acc_o), .idx_o(idx_o), .sp_o(sp_o), .pc_o(pc_o),
        .flags_o(flags_o), .gie_o(gie_o), .bank_o(bank_o));

    always #12.5 core_clk_i = ~core_clk_i;

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // the whole run is well under 400 cycles
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            results();
        end
    end

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic do_reset();
        rst_n_i = 1'b0;
        repeat (20) @(posedge core_clk_i);
        #1 rst_n_i = 1'b1;
        exp_pc = 16'h0000;
        chk("flags", flags_o, 16'h0002);
        chk("acc", acc_o, 16'h0000);
        chk("idx", idx_o, 16'h0000);
        chk("sp", sp_o, 16'h0000);
        chk("pc", pc_o, 16'h0000);
    endtask

    task automatic exec(input crs_pkg::crs_op_t op, input crs_pkg::crs_src_mode_t md, input crs_pkg::crs_dst_t dst,
        input logic rs, input logic [7:0] opnd, input logic [7:0] ea, input logic [1:0] len,
        input logic [15:0] tgt, input logic [7:0] data);
        @(posedge core_clk_i);
        #1 exec_i.op = op;
        exec_i.mode = md;
        exec_i.dst = dst;
        exec_i.reg_space = rs;
        exec_i.operand = opnd;
        exec_i.len = len;
        exec_i.target = tgt;
        exec_valid_i = 1'b1;
        @(posedge core_clk_i);
        #1 exec_valid_i = 1'b0;
        if (md == crs_pkg::CRS_SRC_DIR || md == crs_pkg::CRS_SRC_IDX) begin
            chk("mem_rd", mem_rd_o, 16'h0001);
            chk("busy", busy_o, 16'h0001);
            chk("mem_addr", mem_addr_o, ea);
            chk("mem_space", mem_reg_space_o, rs);
            mem_rdata_i = data;
            @(posedge core_clk_i);
            #1 chk("busy", busy_o, 16'h0000);
        end
        chk("done", done_o, 16'h0001);
        // stale data is inverted so a late sample shows up as a wrong result
        mem_rdata_i = ~data;
        if (op inside {crs_pkg::CRS_OP_CALL, crs_pkg::CRS_OP_LONG_CALL, crs_pkg::CRS_OP_RET, crs_pkg::CRS_OP_INT_RET,
            crs_pkg::CRS_OP_JUMP}) begin
            exp_pc = tgt;
        end else begin
            exp_pc = exp_pc + 16'(len);
        end
        chk("pc", pc_o, exp_pc);
    endtask

    task automatic imm(input crs_pkg::crs_op_t op, input crs_pkg::crs_dst_t dst, input logic [7:0] v);
        exec(op, crs_pkg::CRS_SRC_IMM, dst, 1'b0, v, 8'h00, 2'd2, 16'h0000, 8'h00);
    endtask

    task automatic stk(input crs_pkg::crs_op_t op, input logic [1:0] len, input logic [15:0] tgt, input logic [7:0] e);
        exec(op, crs_pkg::CRS_SRC_NONE, crs_pkg::CRS_DST_A, 1'b0, 8'h00, 8'h00, len, tgt, 8'h00);
        chk("sp", sp_o, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic v, input logic [7:0] e);
        @(posedge core_clk_i);
        #1 reg_addr_i = a;
        reg_rd_i = 1'b1;
        @(posedge core_clk_i);
        #1 reg_rd_i = 1'b0;
        chk("rvalid", reg_rvalid_o, v);
        chk("rdata", reg_rdata_o, e);
    endtask

    initial begin
        do_reset();
        $display("test reset done");
        super_i = 1'b1;
        repeat (2) @(posedge core_clk_i);
        #1 chk("super", flags_o[3], 16'h0001);
        imm(crs_pkg::CRS_OP_OR, crs_pkg::CRS_DST_F, 8'hff);
        chk("flags", flags_o, 16'h001f);
        chk("gie", gie_o, 16'h0001);
        chk("bank", bank_o, 16'h0001);
        imm(crs_pkg::CRS_OP_AND, crs_pkg::CRS_DST_F, 8'h00);
        chk("flags", flags_o, 16'h0008);
        chk("bank", bank_o, 16'h0000);
        chk("gie", gie_o, 16'h0000);
        super_i = 1'b0;
        imm(crs_pkg::CRS_OP_ADD, crs_pkg::CRS_DST_F, 8'hff);
        chk("flags", flags_o, 16'h0000);
        $display("test flags done");
        imm(crs_pkg::CRS_OP_MOV, crs_pkg::CRS_DST_A, 8'h7f);
        chk("acc", acc_o, 16'h007f);
        imm(crs_pkg::CRS_OP_ADD, crs_pkg::CRS_DST_A, 8'h81);
        chk("acc", acc_o, 16'h0000);
        chk("carry_zero", flags_o[2:1], 16'h0003);
        rd(8'hf7, 1'b1, 8'h06);
        rd(8'hf6, 1'b0, 8'h00);
        imm(crs_pkg::CRS_OP_ADD, crs_pkg::CRS_DST_A, 8'h05);
        chk("carry_zero", flags_o[2:1], 16'h0000);
        imm(crs_pkg::CRS_OP_MOV, crs_pkg::CRS_DST_X, 8'hf0);
        imm(crs_pkg::CRS_OP_ADD, crs_pkg::CRS_DST_X, 8'h20);
        chk("idx", idx_o, 16'h0010);
        chk("acc", acc_o, 16'h0005);
        chk("carry_zero", flags_o[2:1], 16'h0002);
        $display("test immediate done");
        exec(crs_pkg::CRS_OP_ADD, crs_pkg::CRS_SRC_DIR, crs_pkg::CRS_DST_A, 1'b0, 8'h07, 8'h07, 2'd2, 16'h0, 8'h0a);
        chk("acc", acc_o, 16'h000f);
        exec(crs_pkg::CRS_OP_MOV, crs_pkg::CRS_SRC_IDX, crs_pkg::CRS_DST_A, 1'b1, 8'hf8, 8'h08, 2'd2, 16'h0, 8'h33);
        chk("acc", acc_o, 16'h0033);
        exec(crs_pkg::CRS_OP_MOV, crs_pkg::CRS_SRC_IDX, crs_pkg::CRS_DST_X, 1'b0, 8'h01, 8'h11, 2'd2, 16'h0, 8'h44);
        chk("idx", idx_o, 16'h0044);
        $display("test memory modes done");
        stk(crs_pkg::CRS_OP_PUSH, 2'd1, 16'h0000, 8'h01);
        stk(crs_pkg::CRS_OP_PUSH, 2'd1, 16'h0000, 8'h02);
        stk(crs_pkg::CRS_OP_CALL, 2'd2, 16'h1234, 8'h04);
        stk(crs_pkg::CRS_OP_RET, 2'd1, 16'h0100, 8'h02);
        stk(crs_pkg::CRS_OP_LONG_CALL, 2'd3, 16'h1ffe, 8'h04);
        stk(crs_pkg::CRS_OP_INT_RET, 2'd1, 16'h0200, 8'h01);
        stk(crs_pkg::CRS_OP_POP, 2'd1, 16'h0000, 8'h00);
        chk("acc", acc_o, 16'h0000);
        imm(crs_pkg::CRS_OP_MOV, crs_pkg::CRS_DST_A, 8'h33);
        imm(crs_pkg::CRS_OP_ADD, crs_pkg::CRS_DST_A, 8'hcd);
        imm(crs_pkg::CRS_OP_ADD, crs_pkg::CRS_DST_SP, 8'h10);
        chk("sp", sp_o, 16'h0010);
        chk("carry_zero", flags_o[2:1], 16'h0003);
        exec(crs_pkg::CRS_OP_SWAP, crs_pkg::CRS_SRC_NONE, crs_pkg::CRS_DST_SP, 1'b0, 8'h0, 8'h0, 2'd1, 16'h0, 8'h0);
        chk("acc", acc_o, 16'h0010);
        chk("sp", sp_o, 16'h0000);
        stk(crs_pkg::CRS_OP_JUMP, 2'd3, 16'hfffe, 8'h00);
        $display("test stack done");
        do_reset();
        $display("test second reset done");
        results();
    end
endmodule
